// ===== bench/adc_port_props.sv
// Checker for the output port configuration block
`timescale 1ns/1ns
`default_nettype none
module adc_port_props #(
   parameter int FAST_GAP_CYCLES = 20
) (
   input wire logic                     hclk,
   input wire logic                     hresetn,
   input wire logic                     hsel,
   input wire logic [1:0]               htrans,
   input wire logic                     hwrite,
   input wire logic                     hready,
   input wire logic                     result_valid,
   input wire logic [15:0]              data_out,
   input wire logic [15:0]              data_oe_n,
   input wire adc_port_pkg::conv_mode_e conv_mode,
   input wire logic                     serial_mode,
   input wire logic                     sclk_internal,
   input wire logic                     frame_active_low,
   input wire logic                     read_during_conv,
   input wire logic [7:0]               sclk_min_cycles
);
   logic xfer;
   logic par;

   // Accepted write address phase; pins may follow it two edges later
   assign xfer = hsel && hready && htrans[1] && hwrite;
   assign par  = !serial_mode;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_OE_PARALLEL: assert property ($past(hresetn) && par && $past(par)
      |-> data_oe_n == 16'h0000) else $error("parallel pins not driven");
   AST_OE_SERIAL: assert property (serial_mode && $past(serial_mode)
      |-> data_oe_n == 16'hFFFF) else $error("serial pins still driven");
   AST_PAR_IGNORE: assert property ($past(hresetn) && par && $past(par)
      |-> !sclk_internal && !frame_active_low && !read_during_conv
          && sclk_min_cycles == 8'h01) else $error("pin inputs used in parallel");
   AST_DIV_RANGE: assert property (sclk_min_cycles inside {8'h01, 8'h02})
      else $error("serial clock count out of range");
   AST_DIV_SERIAL: assert property (sclk_min_cycles == 8'h02
      |-> serial_mode || $past(serial_mode)) else $error("divider outside serial");
   AST_MODE_LEGAL: assert property ($changed(conv_mode) |-> $past(xfer, 3))
      else $error("mode changed without a control write");
   AST_DATA_CAUSED: assert property ($changed(data_out) |-> $past(result_valid)
      || $past(result_valid, 2) || $past(result_valid, 3) || $past(xfer, 2)
      || $past(xfer, 3) || $past(xfer, 4)) else $error("data pins changed alone");
   AST_SER_FLAGS: assert property (sclk_internal || frame_active_low
      |-> serial_mode || $past(serial_mode)) else $error("serial flag in parallel");
endmodule // adc_port_props
`default_nettype wire

// ===== bench/host_pins.sv
// Host side of the shared data pins: straps and pin level resolution
`timescale 1ns/1ns
`default_nettype none
module host_pins (
   input  wire logic [15:0] data_out,
   input  wire logic [15:0] data_oe_n,
   input  wire logic [15:0] straps,
   output logic      [15:0] data_in
);
   // A driven pin shows the device value, a released one the host strap
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         data_in[i] = data_oe_n[i] ? straps[i] : data_out[i];
      end
   end
endmodule // host_pins
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the output port configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int GAP = 20;
   logic                     hclk, hresetn, hsel, hwrite, hready;
   logic                     result_valid, conv_start, hreadyout, hresp;
   logic [31:0]              haddr, hwdata, hrdata, rd;
   logic [1:0]               htrans;
   logic [2:0]               hsize;
   logic [15:0]              result_in, data_in, data_out, data_oe_n;
   logic [15:0]              straps, v, e, s;
   logic [1:0]               d;
   adc_port_pkg::conv_mode_e conv_mode;
   logic                     serial_mode, sclk_internal;
   logic                     frame_active_low, read_during_conv;
   logic [7:0]               sclk_min_cycles;
   int                       failures, n_compared;
   logic [1:0] mode_tab [4] = '{adc_port_pkg::MODE_NORMAL,
      adc_port_pkg::MODE_FAST, adc_port_pkg::MODE_LOW_POWER,
      adc_port_pkg::MODE_NORMAL};
   logic [15:0] st_tab [5] = '{16'h000C, 16'h0028, 16'h001C, 16'h00AC,
      16'h0004};

   assign hready = hreadyout;

   adc_output_port_config #(.FAST_GAP_CYCLES(GAP)) u_dut (.hclk, .hresetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .result_in, .result_valid, .conv_start, .data_in,
      .data_out, .data_oe_n, .conv_mode, .serial_mode, .sclk_internal,
      .frame_active_low, .read_during_conv, .sclk_min_cycles);
   host_pins u_host (.data_out, .data_oe_n, .straps, .data_in);

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   task automatic report_and_stop;
      if (failures == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] got);
      n_compared++;
      if (got !== x)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, x, got);
      end
   endtask

   // Read data is taken at the rising edge that closes the data phase
   task automatic wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         rd = hrdata;
         n++;
      end
      while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1)
      begin
         failures++;
         report_and_stop();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= adc_port_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      #10;
   endtask

   task automatic pulse(input logic [15:0] val, input logic cs);
      @(posedge hclk);
      result_in    <= val;
      result_valid <= !cs;
      conv_start   <= cs;
      @(posedge hclk);
      result_valid <= 1'b0;
      conv_start   <= 1'b0;
      tick(8);
   endtask

   function automatic int cyc(input logic [1:0] d);
      case (d)
         2'h0: return adc_port_pkg::SCLK_CYC0;
         2'h1: return adc_port_pkg::SCLK_CYC1;
         2'h2: return adc_port_pkg::SCLK_CYC2;
         default: return adc_port_pkg::SCLK_CYC3;
      endcase
   endfunction

   initial
   begin
      {hsel, haddr, htrans, hwrite, hwdata, result_in} = '0;
      {result_valid, conv_start, straps, failures, n_compared} = '0;
      hsize   = 3'h2;
      hresetn = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      tick(2);
      chk("oe", 32'h0, {16'h0, data_oe_n});
      bus(1'b0, adc_port_pkg::CTRL_OFF, 32'h0);
      chk("ctrl", {27'h0, adc_port_pkg::CTRL_RESET}, rd);
      bus(1'b0, 8'h0C, 32'h0);
      chk("unmapped", 32'h0, rd);
      // Every coding and byte order pair, sign bit set with normal byte order and clear with swapped
      for (int k = 0; k < 4; k++)
      begin
         v = 16'hA5C3 ^ {k[0], 15'h0};
         bus(1'b1, adc_port_pkg::CTRL_OFF, 32'(k));
         pulse(v, 1'b0);
         e = k[1] ? v : v ^ 16'h8000;
         bus(1'b0, adc_port_pkg::RESULT_OFF, 32'h0);
         chk("result", {16'h0, e}, rd);
         e = k[0] ? {e[7:0], e[15:8]} : e;
         chk("data_out", {16'h0, e}, {16'h0, data_out});
      end
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b1, adc_port_pkg::CTRL_OFF, {27'h0, 2'(k), 3'h2});
         tick(2);
         chk("mode", {30'h0, mode_tab[k]}, {30'h0, conv_mode});
      end
      // Fast mode: steady starts keep accuracy, a long gap loses it
      bus(1'b1, adc_port_pkg::CTRL_OFF, 32'h0A);
      repeat (4) pulse(16'h0, 1'b1);
      bus(1'b0, adc_port_pkg::STATUS_OFF, 32'h0);
      chk("lost", 32'h0, {31'h0, rd[8]});
      tick(GAP + 5);
      bus(1'b0, adc_port_pkg::STATUS_OFF, 32'h0);
      chk("lost", 32'h1, {31'h0, rd[8]});
      bus(1'b1, adc_port_pkg::CTRL_OFF, 32'h02);
      bus(1'b1, adc_port_pkg::STATUS_OFF, 32'h100);
      tick(GAP + 5);
      bus(1'b0, adc_port_pkg::STATUS_OFF, 32'h0);
      chk("lost", 32'h0, {31'h0, rd[8]});
      bus(1'b1, adc_port_pkg::CTRL_OFF, 32'h06);
      tick(2);
      chk("oe", 32'hFFFF, {16'h0, data_oe_n});
      // Straps change only while no conversion runs
      for (int k = 0; k < 5; k++)
      begin
         s = st_tab[k];
         @(posedge hclk);
         straps <= s;
         tick(4);
         chk("sclk", (s[4] || s[7]) ? cyc(2'h0) : cyc(s[3:2]),
             {24'h0, sclk_min_cycles});
         chk("flags", {29'h0, !s[4], s[5], s[7]}, {29'h0, sclk_internal,
             frame_active_low, read_during_conv});
         // Status shows the divider in effect and the borrowed pin levels
         d = (s[4] || s[7]) ? 2'h0 : s[3:2];
         bus(1'b0, adc_port_pkg::STATUS_OFF, 32'h0);
         chk("status", {8'h00, 8'(cyc(d)), 7'h00, 1'b0, 1'b1, s[7], s[5],
             s[4], d, 2'h0}, rd);
      end
      bus(1'b1, adc_port_pkg::CTRL_OFF, 32'h02);
      tick(2);
      chk("oe", 32'h0, {16'h0, data_oe_n});
      report_and_stop();
   end

   initial
   begin
      repeat (20000) @(posedge hclk);
      failures++;
      report_and_stop();
   end
endmodule // tb_top

bind adc_output_port_config adc_port_props #(
   .FAST_GAP_CYCLES(FAST_GAP_CYCLES)) u_props (.hclk, .hresetn, .hsel,
   .htrans, .hwrite, .hready, .result_valid, .data_out, .data_oe_n,
   .conv_mode, .serial_mode, .sclk_internal, .frame_active_low,
   .read_during_conv, .sclk_min_cycles);
`default_nettype wire

// ===== hdl/adc_output_port_config.sv
// Output port configuration, pin sharing and AHB-Lite registers
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module adc_output_port_config #(
   parameter int FAST_GAP_CYCLES = adc_port_pkg::FAST_GAP_CYC
) (
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic      [31:0]                hrdata,
   output logic                            hreadyout,
   output logic                            hresp,
   input  wire logic [15:0]                result_in,
   input  wire logic                       result_valid,
   input  wire logic                       conv_start,
   input  wire logic [15:0]                data_in,
   output logic      [15:0]                data_out,
   output logic      [15:0]                data_oe_n,
   output adc_port_pkg::conv_mode_e        conv_mode,
   output logic                            serial_mode,
   output logic                            sclk_internal,
   output logic                            frame_active_low,
   output logic                            read_during_conv,
   output logic      [7:0]                 sclk_min_cycles
);

   // Bus state
   logic [7:0]                 addr_r;
   logic [7:0]                 addr_nxt;
   logic                       wr_r;
   logic                       wr_nxt;
   logic                       rd_r;
   logic                       rd_nxt;
   // Control and status state
   logic [adc_port_pkg::CTRL_WIDTH-1:0] ctrl_r;
   logic [adc_port_pkg::CTRL_WIDTH-1:0] ctrl_nxt;
   logic                       acc_lost_r;
   logic                       acc_lost_nxt;
   logic [31:0]                gap_cnt_r;
   logic [31:0]                gap_cnt_nxt;
   logic [15:0]                result_r;
   logic [15:0]                result_nxt;
   // Pin side state
   logic [15:0]                pin_meta_r;
   logic [15:0]                pin_sync_r;
   logic [15:0]                data_out_r;
   logic [15:0]                data_out_nxt;
   logic [15:0]                oe_n_r;
   logic [15:0]                oe_n_nxt;
   adc_port_pkg::conv_mode_e   mode_r;
   adc_port_pkg::conv_mode_e   mode_nxt;
   logic [1:0]                 div_r;
   logic [1:0]                 div_nxt;
   logic                       clk_src_r;
   logic                       clk_src_nxt;
   logic                       frame_pol_r;
   logic                       frame_pol_nxt;
   logic                       read_time_r;
   logic                       read_time_nxt;
   logic [7:0]                 sclk_cyc_r;
   logic [7:0]                 sclk_cyc_nxt;
   // Combinational helpers
   logic                       serial;
   logic                       gap_expired;
   logic [15:0]                coded;
   logic [15:0]                ordered;
   logic [15:0]                serial_oe_n;
   logic [31:0]                status_word;

   assign serial = ctrl_r[adc_port_pkg::CTRL_PORT_TYPE];

   // Zero wait state slave; every access completes OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase capture; only NONSEQ or SEQ with hready starts a transfer
   always_comb
   begin
      addr_nxt = addr_r;
      wr_nxt   = 1'b0;
      rd_nxt   = 1'b0;
      if (hsel && hready && (htrans == adc_port_pkg::HTRANS_NONSEQ ||
                             htrans == adc_port_pkg::HTRANS_SEQ))
      begin
         addr_nxt = haddr[7:0];
         wr_nxt   = hwrite;
         rd_nxt   = !hwrite;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_r <= 8'h00;
         wr_r   <= 1'b0;
         rd_r   <= 1'b0;
      end
      else
      begin
         addr_r <= addr_nxt;
         wr_r   <= wr_nxt;
         rd_r   <= rd_nxt;
      end
   end

   // Status word shows the decoded pin and mode state
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[adc_port_pkg::ST_MODE_LO +: 2] = mode_r;
      status_word[adc_port_pkg::ST_DIV_LO +: 2]  = div_r;
      status_word[adc_port_pkg::ST_CLK_SRC]      = clk_src_r;
      status_word[adc_port_pkg::ST_FRAME_POL]    = frame_pol_r;
      status_word[adc_port_pkg::ST_READ_TIME]    = read_time_r;
      status_word[adc_port_pkg::ST_SERIAL]       = serial;
      status_word[adc_port_pkg::ST_ACC_LOST]     = acc_lost_r;
      status_word[adc_port_pkg::ST_SCLK_LO +: 8] = sclk_cyc_r;
   end

   // Read mux in the data phase; unmapped addresses read zero
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (rd_r)
      begin
         if (addr_r == adc_port_pkg::CTRL_OFF)
            hrdata = {27'h0, ctrl_r};
         else if (addr_r == adc_port_pkg::STATUS_OFF)
            hrdata = status_word;
         else if (addr_r == adc_port_pkg::RESULT_OFF)
            hrdata = {16'h0000, coded};
      end
   end

   // Control writes, fast mode rate watchdog and result capture
   always_comb
   begin
      ctrl_nxt     = ctrl_r;
      acc_lost_nxt = acc_lost_r;
      result_nxt   = result_r;
      gap_cnt_nxt  = gap_cnt_r;
      gap_expired  = 1'b0;
      if (wr_r && addr_r == adc_port_pkg::CTRL_OFF)
         ctrl_nxt = hwdata[adc_port_pkg::CTRL_WIDTH-1:0];
      // Write one to clear; a new expiry in the same cycle wins
      if (wr_r && addr_r == adc_port_pkg::STATUS_OFF &&
          hwdata[adc_port_pkg::ST_ACC_LOST])
         acc_lost_nxt = 1'b0;
      // Only the fast mode has a longest gap between starts
      if (mode_r != adc_port_pkg::MODE_FAST || conv_start)
         gap_cnt_nxt = 32'h0000_0000;
      else if (gap_cnt_r < 32'(FAST_GAP_CYCLES))
         gap_cnt_nxt = gap_cnt_r + 32'h0000_0001;
      else
         gap_expired = 1'b1;
      if (gap_expired)
         acc_lost_nxt = 1'b1;
      if (result_valid)
         result_nxt = result_in;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_r     <= adc_port_pkg::CTRL_RESET;
         acc_lost_r <= 1'b0;
         gap_cnt_r  <= 32'h0000_0000;
         result_r   <= 16'h0000;
      end
      else
      begin
         ctrl_r     <= ctrl_nxt;
         acc_lost_r <= acc_lost_nxt;
         gap_cnt_r  <= gap_cnt_nxt;
         result_r   <= result_nxt;
      end
   end

   // Two-stage synchroniser on the shared data pins
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_meta_r <= 16'h0000;
         pin_sync_r <= 16'h0000;
      end
      else
      begin
         pin_meta_r <= data_in;
         pin_sync_r <= pin_meta_r;
      end
   end

   // Output coding then byte order
   always_comb
   begin
      coded = result_r;
      if (!ctrl_r[adc_port_pkg::CTRL_OUT_CODE])
         coded[15] = !result_r[15];
      if (ctrl_r[adc_port_pkg::CTRL_BYTE_ORD])
         ordered = {coded[7:0], coded[15:8]};
      else
         ordered = coded;
   end

   // Pins not listed as serial controls stay released in serial mode
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_pin
         // Pins 0 and 1 float; borrowed pins turn into inputs
         assign serial_oe_n[gi] = 1'b1;
      end
   endgenerate

   // Pin drive, conversion mode and serial settings
   always_comb
   begin
      data_out_nxt  = ordered;
      oe_n_nxt      = serial ? serial_oe_n : 16'h0000;
      mode_nxt      = adc_port_pkg::MODE_NORMAL;
      clk_src_nxt   = 1'b0;
      frame_pol_nxt = 1'b0;
      read_time_nxt = 1'b0;
      div_nxt       = 2'b00;
      if (ctrl_r[adc_port_pkg::CTRL_FAST] &&
          !ctrl_r[adc_port_pkg::CTRL_LOW_PWR])
         mode_nxt = adc_port_pkg::MODE_FAST;
      else if (!ctrl_r[adc_port_pkg::CTRL_FAST] &&
               ctrl_r[adc_port_pkg::CTRL_LOW_PWR])
         mode_nxt = adc_port_pkg::MODE_LOW_POWER;
      if (serial)
      begin
         clk_src_nxt   = pin_sync_r[adc_port_pkg::PIN_CLK_SRC];
         frame_pol_nxt = pin_sync_r[adc_port_pkg::PIN_FRAME_POL];
         read_time_nxt = pin_sync_r[adc_port_pkg::PIN_READ_TIME];
         // Divider pins only count for internal clock, read after convert
         if (!clk_src_nxt && !read_time_nxt)
            div_nxt = {pin_sync_r[adc_port_pkg::PIN_DIV_HI],
                       pin_sync_r[adc_port_pkg::PIN_DIV_LO]};
      end
      case (div_nxt)
         2'b00:   sclk_cyc_nxt = 8'(adc_port_pkg::SCLK_CYC0);
         2'b01:   sclk_cyc_nxt = 8'(adc_port_pkg::SCLK_CYC1);
         2'b10:   sclk_cyc_nxt = 8'(adc_port_pkg::SCLK_CYC2);
         default: sclk_cyc_nxt = 8'(adc_port_pkg::SCLK_CYC3);
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         data_out_r  <= 16'h0000;
         oe_n_r      <= 16'hFFFF;
         mode_r      <= adc_port_pkg::MODE_NORMAL;
         clk_src_r   <= 1'b0;
         frame_pol_r <= 1'b0;
         read_time_r <= 1'b0;
         div_r       <= 2'b00;
         sclk_cyc_r  <= 8'(adc_port_pkg::SCLK_CYC0);
      end
      else
      begin
         data_out_r  <= data_out_nxt;
         oe_n_r      <= oe_n_nxt;
         mode_r      <= mode_nxt;
         clk_src_r   <= clk_src_nxt;
         frame_pol_r <= frame_pol_nxt;
         read_time_r <= read_time_nxt;
         div_r       <= div_nxt;
         sclk_cyc_r  <= sclk_cyc_nxt;
      end
   end

   // Registered outputs except sclk_internal, an AND of serial and inverted clk_src_r; selects are assumed stable across a conversion
   assign data_out         = data_out_r;
   assign data_oe_n        = oe_n_r;
   assign conv_mode        = mode_r;
   assign serial_mode      = serial;
   assign sclk_internal    = serial && !clk_src_r;
   assign frame_active_low = frame_pol_r;
   assign read_during_conv = read_time_r;
   assign sclk_min_cycles  = sclk_cyc_r;

endmodule // adc_output_port_config

`default_nettype wire

// ===== hdl/adc_port_pkg.sv
// Shared constants and types for the converter output port configuration
package adc_port_pkg;

   // Register byte offsets on the AHB-Lite bus
   localparam logic [7:0]  CTRL_OFF       = 8'h00;
   localparam logic [7:0]  STATUS_OFF     = 8'h04;
   localparam logic [7:0]  RESULT_OFF     = 8'h08;

   // Control register field positions
   localparam int          CTRL_BYTE_ORD  = 0;
   localparam int          CTRL_OUT_CODE  = 1;
   localparam int          CTRL_PORT_TYPE = 2;
   localparam int          CTRL_FAST      = 3;
   localparam int          CTRL_LOW_PWR   = 4;
   localparam int          CTRL_WIDTH     = 5;
   // Straight binary out of reset, parallel port, normal mode
   localparam logic [4:0]  CTRL_RESET     = 5'h02;

   // Status register field positions
   localparam int          ST_MODE_LO     = 0;
   localparam int          ST_DIV_LO      = 2;
   localparam int          ST_CLK_SRC     = 4;
   localparam int          ST_FRAME_POL   = 5;
   localparam int          ST_READ_TIME   = 6;
   localparam int          ST_SERIAL      = 7;
   localparam int          ST_ACC_LOST    = 8;
   localparam int          ST_SCLK_LO     = 16;

   // Data pins borrowed by the serial port
   localparam int          PIN_DIV_LO     = 2;
   localparam int          PIN_DIV_HI     = 3;
   localparam int          PIN_CLK_SRC    = 4;
   localparam int          PIN_FRAME_POL  = 5;
   localparam int          PIN_READ_TIME  = 7;

   // Timing: clock period and minimum internal serial clock periods
   localparam int          CLK_PERIOD_NS  = 100;
   localparam int          SCLK_MIN_NS0   = 25;
   localparam int          SCLK_MIN_NS1   = 50;
   localparam int          SCLK_MIN_NS2   = 100;
   localparam int          SCLK_MIN_NS3   = 200;
   // Least times round up, never below one cycle
   localparam int          SCLK_CYC0 = (SCLK_MIN_NS0 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int          SCLK_CYC1 = (SCLK_MIN_NS1 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int          SCLK_CYC2 = (SCLK_MIN_NS2 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int          SCLK_CYC3 = (SCLK_MIN_NS3 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;

   // Longest gap between conversion starts in the fast mode
   localparam int          FAST_GAP_NS    = 1000000;
   localparam int          FAST_GAP_CYC   = FAST_GAP_NS / CLK_PERIOD_NS;

   // AHB encodings
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_FAST,
      MODE_LOW_POWER
   } conv_mode_e;

endpackage
